// ---- src/pmirq_regs.sv ----
// Implementation choice: register access over APB.
`timescale 1ns/10ps
// Summary of operation
// - A one written to an enable-clear bit clears that enable and thereby its request; zero does nothing.
// - A one written to the clock ready bit of enable-set sets that enable; zero does nothing.
// - Clock ready enable and flag both set raise the request; both enable registers read one shared state.
// - The clock failure enable is bit one of both enable registers and with its flag raises the request.
// - The clock ready flag sets when the processor and bus clocks reach their selected divisions.
// - The clock ready flag clears only by writing one to it in the flag register or the interrupt clear register.
// - The reset record sets bit six on a system request reset and bit five on a watchdog reset, read-only.
// - The reset record sets bit four on a reset from the external pin.
// - The reset record sets bit two on an I/O brown-out reset and bit one on a core brown-out reset.
// - After power-on the reset record reads 0x01.
module pmirq_regs (
	// Clock and reset.
	input  wire logic                          core_clk_i,
	input  wire logic                          reset_n_i,
	// APB slave.
	input  wire logic                          psel_i,
	input  wire logic                          penable_i,
	input  wire logic                          pwrite_i,
	input  wire logic [11:0]                   paddr_i,
	input  wire logic [31:0]                   pwdata_i,
	input  wire logic [3:0]                    pstrb_i,
	output logic      [31:0]                   prdata_o,
	output logic                               pready_o,
	output logic                               pslverr_o,
	// Clock generator status, same clock domain.
	input  wire logic                          clock_ready_i,
	input  wire logic                          clock_failure_detect_i,
	// Reset controller cause, held stable across the reset.
	input  wire pmirq_pkg::pmirq_reset_cause_t reset_cause_i,
	// Interrupt request to the interrupt controller.
	output logic                               irq_o
);

	// Register state.
	pmirq_pkg::pmirq_irq_bits_t enable_reg, enable_next;
	pmirq_pkg::pmirq_irq_bits_t flags_reg, flags_next;
	logic [7:0]                 reset_source_reg, reset_source_next;
	logic                       captured_reg;
	logic                       clock_ready_seen_reg;
	logic [31:0]                prdata_reg, prdata_next;
	logic                       irq_reg;

	// Address decode.
	wire logic hit_enable_clear = paddr_i == pmirq_pkg::PMIRQ_ADDR_ENABLE_CLEAR;
	wire logic hit_enable_set   = paddr_i == pmirq_pkg::PMIRQ_ADDR_ENABLE_SET;
	wire logic hit_flags        = paddr_i == pmirq_pkg::PMIRQ_ADDR_FLAGS;
	wire logic hit_reset_source = paddr_i == pmirq_pkg::PMIRQ_ADDR_RESET_SOURCE;
	wire logic hit_irq_status   = paddr_i == pmirq_pkg::PMIRQ_ADDR_IRQ_STATUS;
	wire logic hit_irq_clear    = paddr_i == pmirq_pkg::PMIRQ_ADDR_IRQ_CLEAR;
	wire logic hit_any          = hit_enable_clear | hit_enable_set | hit_flags
	                            | hit_reset_source | hit_irq_status | hit_irq_clear;

	// Access phase qualifiers; the low byte lane must be strobed for a write to act.
	wire logic access    = psel_i & penable_i;
	wire logic wr_low    = access & pwrite_i & pstrb_i[0] & hit_any;
	wire logic [1:0] wbits = pwdata_i[1:0];
	wire logic [1:0] en_clr = (wr_low & hit_enable_clear) ? wbits : 2'h0;
	wire logic [1:0] en_set = (wr_low & hit_enable_set) ? wbits : 2'h0;
	wire logic [1:0] fl_clr = (wr_low & (hit_flags | hit_irq_clear)) ? wbits : 2'h0;

	// Event detection: clock ready is taken on its rising level, a failure on any high cycle.
	wire logic ready_event   = clock_ready_i & ~clock_ready_seen_reg;
	wire logic failure_event = clock_failure_detect_i;

	// Next enable: clear and set views share one state.
	assign enable_next = pmirq_pkg::pmirq_irq_bits_t'((enable_reg & ~en_clr) | en_set);

	// Next flags: a one clears, a zero leaves the bit, and an event in the same cycle wins.
	assign flags_next.clock_ready =
		(flags_reg.clock_ready & ~fl_clr[pmirq_pkg::PMIRQ_BIT_CLOCK_READY]) | ready_event;
	assign flags_next.clock_failure_detect =
		(flags_reg.clock_failure_detect & ~fl_clr[pmirq_pkg::PMIRQ_BIT_CLOCK_FAILURE_DETECT])
		| failure_event;

	// Reset record: causes gathered into their documented bit positions.
	assign reset_source_next = {
		1'b0,
		reset_cause_i.system_request_reset,
		reset_cause_i.watchdog_reset,
		reset_cause_i.external_pin_reset,
		1'b0,
		reset_cause_i.io_brownout_reset,
		reset_cause_i.core_brownout_reset,
		reset_cause_i.power_on_reset
	} & pmirq_pkg::PMIRQ_RESET_SOURCE_MASK;

	// Read data, selected during the setup cycle so it is registered by the access cycle.
	assign prdata_next =
		(hit_enable_clear | hit_enable_set) ? {30'h0000_0000, enable_reg} :
		(hit_flags | hit_irq_status)        ? {30'h0000_0000, flags_reg} :
		hit_reset_source                    ? {24'h00_0000, reset_source_reg} :
		32'h0000_0000;

	// Bus answer: zero wait states, error on an unmapped address.
	assign pready_o  = 1'b1;
	assign pslverr_o = access & ~hit_any;
	assign prdata_o  = prdata_reg;
	assign irq_o     = irq_reg;

	// Interrupt enable and flag registers.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			enable_reg           <= pmirq_pkg::pmirq_irq_bits_t'(pmirq_pkg::PMIRQ_ENABLE_RESET);
			flags_reg            <= pmirq_pkg::pmirq_irq_bits_t'(pmirq_pkg::PMIRQ_FLAGS_RESET);
			clock_ready_seen_reg <= 1'b0;
		end else begin
			enable_reg           <= enable_next;
			flags_reg            <= flags_next;
			clock_ready_seen_reg <= clock_ready_i;
		end
	end

	// Reset record: constant at reset, cause caught once at the first edge after release.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_source_reg <= pmirq_pkg::PMIRQ_RESET_SOURCE_RESET;
			captured_reg     <= 1'b0;
		end else if (!captured_reg) begin
			reset_source_reg <= reset_source_next;
			captured_reg     <= 1'b1;
		end
	end

	// Read data and interrupt line.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prdata_reg <= 32'h0000_0000;
			irq_reg    <= 1'b0;
		end else begin
			if (psel_i & ~penable_i & ~pwrite_i) begin
				prdata_reg <= prdata_next;
			end
			irq_reg <= |(enable_next & flags_next);
		end
	end

endmodule

// ---- src/pmirq_pkg.sv ----
package pmirq_pkg;

	// Printed register indices; the APB byte address is four times the index.
	localparam logic [7:0]  PMIRQ_IDX_ENABLE_CLEAR = 8'h34;
	localparam logic [7:0]  PMIRQ_IDX_ENABLE_SET   = 8'h35;
	localparam logic [7:0]  PMIRQ_IDX_FLAGS        = 8'h36;
	localparam logic [7:0]  PMIRQ_IDX_RESET_SOURCE = 8'h38;
	localparam logic [7:0]  PMIRQ_IDX_IRQ_STATUS   = 8'h39;
	localparam logic [7:0]  PMIRQ_IDX_IRQ_CLEAR    = 8'h3A;

	// Byte addresses derived from the indices.
	localparam logic [11:0] PMIRQ_ADDR_ENABLE_CLEAR = {2'h0, PMIRQ_IDX_ENABLE_CLEAR, 2'h0};
	localparam logic [11:0] PMIRQ_ADDR_ENABLE_SET   = {2'h0, PMIRQ_IDX_ENABLE_SET, 2'h0};
	localparam logic [11:0] PMIRQ_ADDR_FLAGS        = {2'h0, PMIRQ_IDX_FLAGS, 2'h0};
	localparam logic [11:0] PMIRQ_ADDR_RESET_SOURCE = {2'h0, PMIRQ_IDX_RESET_SOURCE, 2'h0};
	localparam logic [11:0] PMIRQ_ADDR_IRQ_STATUS   = {2'h0, PMIRQ_IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] PMIRQ_ADDR_IRQ_CLEAR    = {2'h0, PMIRQ_IDX_IRQ_CLEAR, 2'h0};

	// Interrupt bit positions, shared by enable, flag, status and clear views.
	localparam int PMIRQ_BIT_CLOCK_READY          = 0;
	localparam int PMIRQ_BIT_CLOCK_FAILURE_DETECT = 1;

	// Reset source bit positions.
	localparam int PMIRQ_RST_POWER_ON       = 0;
	localparam int PMIRQ_RST_CORE_BROWNOUT  = 1;
	localparam int PMIRQ_RST_IO_BROWNOUT    = 2;
	localparam int PMIRQ_RST_EXTERNAL_PIN   = 4;
	localparam int PMIRQ_RST_WATCHDOG       = 5;
	localparam int PMIRQ_RST_SYSTEM_REQUEST = 6;

	// Reset values.
	localparam logic [1:0] PMIRQ_ENABLE_RESET       = 2'h0;
	localparam logic [1:0] PMIRQ_FLAGS_RESET        = 2'h0;
	localparam logic [7:0] PMIRQ_RESET_SOURCE_RESET = 8'h01;
	localparam logic [7:0] PMIRQ_RESET_SOURCE_MASK  = 8'h77;

	// Interrupt sources carried together.
	typedef struct packed {
		logic clock_failure_detect;
		logic clock_ready;
	} pmirq_irq_bits_t;

	// Reset causes reported by the reset controller.
	typedef struct packed {
		logic system_request_reset;
		logic watchdog_reset;
		logic external_pin_reset;
		logic io_brownout_reset;
		logic core_brownout_reset;
		logic power_on_reset;
	} pmirq_reset_cause_t;

endpackage

// ---- test/pmirq_props.sv ----
`timescale 1ns/10ps
module pmirq_props (
	// Bus, status and interrupt ports of the block.
	input wire logic core_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
	input wire logic clock_ready_i, clock_failure_detect_i, irq_o,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i, prdata_o,
	input wire logic [3:0] pstrb_i,
	input wire pmirq_pkg::pmirq_reset_cause_t reset_cause_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Decode of completed accesses.
	wire acc = psel_i && penable_i;
	wire wr = acc && pwrite_i && pstrb_i[0];
	wire mapped = paddr_i inside {12'h0D0, 12'h0D4, 12'h0D8, 12'h0E0, 12'h0E4, 12'h0E8};
	wire w_clr = wr && paddr_i == 12'h0D0;
	wire w_set = wr && paddr_i == 12'h0D4;
	wire w_flg = wr && paddr_i == 12'h0D8;
	wire w_any = wr && paddr_i inside {12'h0D0, 12'h0D8, 12'h0E8} && |pwdata_i[1:0];
	wire [5:0] rc = reset_cause_i;
	a_ready_always: assert property (pready_o) else $error("pready low");
	a_unmapped_err: assert property (acc |-> pslverr_o == !mapped) else $error("bad pslverr");
	a_clear_irq_off: assert property (w_clr && pwdata_i[1:0] == 2'h3 |=> !irq_o)
		else $error("irq after enable clear");
	a_fail_irq_on: assert property (w_set && pwdata_i[1] ##2 clock_failure_detect_i && !w_clr
		|=> irq_o) else $error("no failure irq");
	a_ready_irq_on: assert property (w_set && pwdata_i[0] ##2 $rose(clock_ready_i) && !w_clr
		|=> irq_o) else $error("no ready irq");
	a_irq_sticky: assert property (irq_o && !w_any |=> irq_o) else $error("irq dropped");
	a_flag_clear: assert property (w_flg && pwdata_i[1:0] == 2'h3 && !clock_ready_i
		&& !clock_failure_detect_i |=> !irq_o) else $error("flags not cleared");
	a_record_value: assert property (acc && !pwrite_i && paddr_i == 12'h0E0
		|-> prdata_o == {25'h0, rc[5:3], 1'b0, rc[2:0]}) else $error("bad reset record");
endmodule
bind pmirq_regs pmirq_props pmirq_props_i (.*);

// ---- test/pmirq_clk_src.sv ----
`timescale 1ns/10ps
module pmirq_clk_src (
	input  wire logic core_clk_i,
	input  wire logic ready_req_i,
	input  wire logic fail_req_i,
	output logic      clock_ready_o,
	output logic      clock_failure_detect_o
);
	// Status leaves a register, as the clock generator's own would.
	always_ff @(posedge core_clk_i) begin
		clock_ready_o <= ready_req_i;
		clock_failure_detect_o <= fail_req_i;
	end
endmodule

// ---- test/pmirq_regs_test.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module pmirq_regs_test;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rdy_req = 0, fail_req = 0, err;
	logic [11:0] addr = 0;
	logic [31:0] wdata = 0, rdata, prdata;
	logic pready, pslverr, ck_rdy, ck_fail, irq;
	pmirq_pkg::pmirq_reset_cause_t cause = 6'h01;
	int n_fail = 0, num_checks = 0;
	// Clock and watchdog.
	initial forever #12.5 clk = ~clk;
	initial begin repeat (3000) @(posedge clk); n_fail++; conclude; end
	pmirq_regs pmirq_regs_i (.core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdata), .pstrb_i(4'hF), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .clock_ready_i(ck_rdy), .irq_o(irq),
		.clock_failure_detect_i(ck_fail), .reset_cause_i(cause));
	pmirq_clk_src pmirq_clk_src_i (.core_clk_i(clk), .ready_req_i(rdy_req), .fail_req_i(fail_req),
		.clock_ready_o(ck_rdy), .clock_failure_detect_o(ck_fail));
	// One APB transfer; answer taken at the edge where pready is seen.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk); psel <= 1; pwr <= w; addr <= a; wdata <= d;
		@(posedge clk); pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata; err = pslverr; psel <= 0; pen <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0); `CHK("rdata", e, rdata)
	endtask
	task automatic reboot(input logic [5:0] c);
		@(posedge clk); rst_n <= 0; cause <= c;
		repeat (4) @(posedge clk); rst_n <= 1; repeat (2) @(posedge clk);
	endtask
	task automatic irq_is(input logic e);
		@(negedge clk); `CHK("irq", e, irq)
	endtask
	task automatic conclude;
		if (n_fail == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Register sequences with expected values.
	initial begin
		reboot(6'h01); rd(12'h0E0, 32'h1);
		rd(12'h0D0, 32'h0); rd(12'h0D8, 32'h0);
		apb(1, 12'h0E0, 32'hFF); rd(12'h0E0, 32'h1);
		for (int i = 1; i < 6; i++) begin
			reboot(6'(1 << i)); rd(12'h0E0, 32'(i < 3 ? 1 << i : 2 << i));
		end
		reboot(6'h01);
		apb(1, 12'h0D4, 32'h1); rdy_req <= 1; apb(1, 12'h0D4, 32'h0);
		rd(12'h0D0, 32'h1); irq_is(1);
		@(posedge clk); rdy_req <= 0; apb(1, 12'h0D8, 32'h0); irq_is(1);
		apb(1, 12'h0D8, 32'h3); irq_is(0);
		apb(1, 12'h0D4, 32'h2); fail_req <= 1; @(posedge clk); fail_req <= 0;
		rd(12'h0D4, 32'h3); irq_is(1); rd(12'h0D8, 32'h2);
		apb(1, 12'h0D0, 32'h0); irq_is(1); apb(1, 12'h0D0, 32'h2); irq_is(0);
		rd(12'h0D0, 32'h1); apb(1, 12'h0D4, 32'h2); irq_is(1);
		apb(1, 12'h0D0, 32'h3); irq_is(0); rd(12'h0D4, 32'h0);
		apb(1, 12'h0E8, 32'h2); rd(12'h0D8, 32'h0);
		apb(0, 12'h0DC, 0); `CHK("pslverr", 1'b1, err)
		conclude;
	end
endmodule
